/* File: design/aer_map.svh */
// Register offsets, field positions and reset values of the error report bank
`ifndef AER_MAP_SVH
`define AER_MAP_SVH

`define AER_ADDR_W 12
`define AER_OFF_CORR_STATUS 12'h110
`define AER_OFF_CORR_MASK 12'h114
`define AER_OFF_ERR_CTRL 12'h118
`define AER_OFF_HDR_LOG1 12'h11c
`define AER_OFF_HDR_LOG2 12'h120
`define AER_OFF_HDR_LOG3 12'h124
`define AER_OFF_HDR_LOG4 12'h128
`define AER_OFF_IRQ_STATUS 12'h140
`define AER_OFF_IRQ_CLEAR 12'h144
`define AER_OFF_IRQ_ENABLE 12'h148
`define AER_OFF_LOCK 12'h14c

`define AER_BIT_RCV_ERR 0
`define AER_BIT_BAD_PKT 6
`define AER_BIT_BAD_LINK_PKT 7
`define AER_BIT_REPLAY_ROLL 8
`define AER_BIT_REPLAY_TO 12
`define AER_BIT_ADVISORY 13
`define AER_CORR_IMPL (32'h00003000 | 32'h000001c1)
`define AER_CORR_MASK_RST 32'h00002000

`define AER_FEP_LSB 0
`define AER_FEP_MSB 4
`define AER_BIT_GEN_CAP 5
`define AER_BIT_GEN_EN 6
`define AER_BIT_CHK_CAP 7
`define AER_BIT_CHK_EN 8
`define AER_GEN_CAP_RST 1'h1
`define AER_CHK_CAP_RST 1'h1

`define AER_IRQ_CORR 0
`define AER_IRQ_UNCORR 1
`define AER_IRQ_W 2

`endif

/* File: design/aer_pkg.sv */
// Types shared by the error report bank
`default_nettype none
package aer_pkg;
    typedef logic [31:0] aer_word_t;
    typedef logic [11:0] aer_addr_t;
    typedef logic [4:0] aer_ptr_t;
    typedef enum logic {AER_LOG_OPEN, AER_LOG_HELD} aer_log_e;
endpackage : aer_pkg
`default_nettype wire

/* File: design/aer_hdr_log.sv */
// First-error header capture: four log words and the first error pointer
`include "aer_map.svh"
`default_nettype none
module aer_hdr_log (
    // Clock and power-on reset; the whole log is sticky
    input wire logic sys_clk,
    input wire logic sticky_rst_n,
    // Uncorrectable error report from the transaction layer
    input wire logic uerr_valid,
    input wire aer_pkg::aer_ptr_t uerr_bit,
    input wire aer_pkg::aer_word_t uerr_hdr [4],
    // Software releases the log once it was read
    input wire logic log_release,
    // Captured state
    output aer_pkg::aer_word_t hdr_word [4],
    output aer_pkg::aer_ptr_t first_ptr,
    output logic captured
);
    import aer_pkg::*;

    aer_log_e state_reg;
    aer_log_e state_next;
    aer_word_t hdr_reg [4];
    aer_word_t hdr_next [4];
    aer_ptr_t ptr_reg;
    aer_ptr_t ptr_next;
    logic take;

    always_comb begin
        state_next = state_reg;
        take = 1'b0;
        case (state_reg)
            AER_LOG_OPEN: begin
                if (uerr_valid) begin
                    take = 1'b1;
                    state_next = AER_LOG_HELD;
                end
            end
            AER_LOG_HELD: begin
                // Later errors do not disturb a held log
                if (log_release) begin
                    state_next = AER_LOG_OPEN;
                end
            end
            default: state_next = AER_LOG_OPEN;
        endcase
        ptr_next = take ? uerr_bit : ptr_reg;
    end

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_word
            assign hdr_next[i] = take ? uerr_hdr[i] : hdr_reg[i];
            // Sticky: only the power-on reset clears the log
            always_ff @(posedge sys_clk or negedge sticky_rst_n) begin
                if (!sticky_rst_n) begin
                    hdr_reg[i] <= 32'h0;
                end else begin
                    hdr_reg[i] <= hdr_next[i];
                end
            end
            assign hdr_word[i] = hdr_reg[i];
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge sticky_rst_n) begin
        if (!sticky_rst_n) begin
            state_reg <= AER_LOG_OPEN;
            ptr_reg <= 5'h0;
        end else begin
            state_reg <= state_next;
            ptr_reg <= ptr_next;
        end
    end

    assign first_ptr = ptr_reg;
    assign captured = (state_reg == AER_LOG_HELD);
endmodule : aer_hdr_log
`default_nettype wire

/* File: design/aer_regs.sv */
// Correctable mask, error control and header log registers of one switch port
`include "aer_map.svh"
`default_nettype none
module aer_regs (
    // Clock and resets
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic sticky_rst_n,
    // Register port
    input wire aer_pkg::aer_addr_t reg_addr,
    input wire aer_pkg::aer_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output aer_pkg::aer_word_t reg_rdata,
    // Correctable events, one-cycle pulses
    input wire logic ev_rcv_err,
    input wire logic ev_bad_pkt,
    input wire logic ev_bad_link_pkt,
    input wire logic ev_replay_roll,
    input wire logic ev_replay_to,
    input wire logic ev_advisory,
    // Uncorrectable error with its header
    input wire logic uerr_valid,
    input wire aer_pkg::aer_ptr_t uerr_bit,
    input wire aer_pkg::aer_word_t uerr_hdr [4],
    // Reports and controls
    output logic corr_report,
    output logic crc_gen_enable,
    output logic crc_check_enable,
    output logic irq
);
    import aer_pkg::*;

    aer_word_t corr_status_reg;
    aer_word_t corr_status_next;
    aer_word_t corr_mask_reg;
    aer_word_t corr_mask_next;
    logic gen_cap_reg;
    logic gen_cap_next;
    logic chk_cap_reg;
    logic chk_cap_next;
    logic gen_en_reg;
    logic gen_en_next;
    logic chk_en_reg;
    logic chk_en_next;
    logic lock_reg;
    logic lock_next;
    logic [`AER_IRQ_W-1:0] irq_status_reg;
    logic [`AER_IRQ_W-1:0] irq_status_next;
    logic [`AER_IRQ_W-1:0] irq_en_reg;
    logic [`AER_IRQ_W-1:0] irq_en_next;
    aer_word_t rdata_reg;
    aer_word_t rdata_next;
    logic report_reg;
    logic report_next;
    aer_word_t ev_vec;
    aer_word_t impl;
    aer_word_t hdr_word [4];
    aer_ptr_t first_ptr;
    logic captured;
    logic log_release;
    logic wr_status;
    logic wr_mask;
    logic wr_ctrl;
    logic uerr_new;

    aer_hdr_log u_log (
        .sys_clk(sys_clk),
        .sticky_rst_n(sticky_rst_n),
        .uerr_valid(uerr_valid),
        .uerr_bit(uerr_bit),
        .uerr_hdr(uerr_hdr),
        .log_release(log_release),
        .hdr_word(hdr_word),
        .first_ptr(first_ptr),
        .captured(captured)
    );

    always_comb begin
        impl = `AER_CORR_IMPL;
        ev_vec = 32'h0;
        ev_vec[`AER_BIT_RCV_ERR] = ev_rcv_err;
        ev_vec[`AER_BIT_BAD_PKT] = ev_bad_pkt;
        ev_vec[`AER_BIT_BAD_LINK_PKT] = ev_bad_link_pkt;
        ev_vec[`AER_BIT_REPLAY_ROLL] = ev_replay_roll;
        ev_vec[`AER_BIT_REPLAY_TO] = ev_replay_to;
        ev_vec[`AER_BIT_ADVISORY] = ev_advisory;
        wr_status = reg_wr && (reg_addr == `AER_OFF_CORR_STATUS);
        wr_mask = reg_wr && (reg_addr == `AER_OFF_CORR_MASK);
        wr_ctrl = reg_wr && (reg_addr == `AER_OFF_ERR_CTRL);
        // Clearing the uncorrectable interrupt bit reopens the log
        log_release = reg_wr && (reg_addr == `AER_OFF_IRQ_CLEAR)
            && reg_wdata[`AER_IRQ_UNCORR];
        uerr_new = uerr_valid && !captured;
    end

    // Status: event set wins over a write-one clear in the same cycle
    always_comb begin
        corr_status_next = corr_status_reg;
        if (wr_status) begin
            corr_status_next = corr_status_next & ~(reg_wdata & impl);
        end
        corr_status_next = (corr_status_next | ev_vec) & impl;
        // Report only events whose mask bit is clear
        report_next = |(ev_vec & ~corr_mask_reg & impl);
    end

    always_comb begin
        corr_mask_next = corr_mask_reg;
        if (wr_mask) begin
            corr_mask_next = reg_wdata & impl;
        end
    end

    // Control: capability bits follow the lock
    always_comb begin
        gen_cap_next = gen_cap_reg;
        chk_cap_next = chk_cap_reg;
        gen_en_next = gen_en_reg;
        chk_en_next = chk_en_reg;
        lock_next = lock_reg;
        if (wr_ctrl) begin
            if (!lock_reg) begin
                gen_cap_next = reg_wdata[`AER_BIT_GEN_CAP];
                chk_cap_next = reg_wdata[`AER_BIT_CHK_CAP];
            end
            gen_en_next = reg_wdata[`AER_BIT_GEN_EN];
            chk_en_next = reg_wdata[`AER_BIT_CHK_EN];
        end
        if (reg_wr && (reg_addr == `AER_OFF_LOCK)) begin
            lock_next = reg_wdata[0];
        end
    end

    // Interrupt status: set wins over clear
    always_comb begin
        irq_status_next = irq_status_reg;
        irq_en_next = irq_en_reg;
        if (reg_wr && (reg_addr == `AER_OFF_IRQ_CLEAR)) begin
            irq_status_next = irq_status_next & ~reg_wdata[`AER_IRQ_W-1:0];
        end
        irq_status_next[`AER_IRQ_CORR] = irq_status_next[`AER_IRQ_CORR] | report_next;
        irq_status_next[`AER_IRQ_UNCORR] = irq_status_next[`AER_IRQ_UNCORR] | uerr_new;
        if (reg_wr && (reg_addr == `AER_OFF_IRQ_ENABLE)) begin
            irq_en_next = reg_wdata[`AER_IRQ_W-1:0];
        end
    end

    always_comb begin
        rdata_next = 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                `AER_OFF_CORR_STATUS: rdata_next = corr_status_reg;
                `AER_OFF_CORR_MASK: rdata_next = corr_mask_reg & impl;
                `AER_OFF_ERR_CTRL: begin
                    rdata_next[`AER_FEP_MSB:`AER_FEP_LSB] = first_ptr;
                    rdata_next[`AER_BIT_GEN_CAP] = gen_cap_reg;
                    rdata_next[`AER_BIT_GEN_EN] = gen_en_reg;
                    rdata_next[`AER_BIT_CHK_CAP] = chk_cap_reg;
                    rdata_next[`AER_BIT_CHK_EN] = chk_en_reg;
                end
                `AER_OFF_HDR_LOG1: rdata_next = hdr_word[0];
                `AER_OFF_HDR_LOG2: rdata_next = hdr_word[1];
                `AER_OFF_HDR_LOG3: rdata_next = hdr_word[2];
                `AER_OFF_HDR_LOG4: rdata_next = hdr_word[3];
                `AER_OFF_IRQ_STATUS: rdata_next[`AER_IRQ_W-1:0] = irq_status_reg;
                `AER_OFF_IRQ_ENABLE: rdata_next[`AER_IRQ_W-1:0] = irq_en_reg;
                `AER_OFF_LOCK: rdata_next[0] = lock_reg;
                default: rdata_next = 32'h0;
            endcase
        end
    end

    // Sticky group: kept through ordinary resets
    always_ff @(posedge sys_clk or negedge sticky_rst_n) begin
        if (!sticky_rst_n) begin
            corr_status_reg <= 32'h0;
            corr_mask_reg <= `AER_CORR_MASK_RST;
            gen_en_reg <= 1'b0;
            chk_en_reg <= 1'b0;
        end else begin
            corr_status_reg <= corr_status_next;
            corr_mask_reg <= corr_mask_next;
            gen_en_reg <= gen_en_next;
            chk_en_reg <= chk_en_next;
        end
    end

    // Ordinary group
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gen_cap_reg <= `AER_GEN_CAP_RST;
            chk_cap_reg <= `AER_CHK_CAP_RST;
            lock_reg <= 1'b0;
            irq_status_reg <= 2'h0;
            irq_en_reg <= 2'h0;
            rdata_reg <= 32'h0;
            report_reg <= 1'b0;
        end else begin
            gen_cap_reg <= gen_cap_next;
            chk_cap_reg <= chk_cap_next;
            lock_reg <= lock_next;
            irq_status_reg <= irq_status_next;
            irq_en_reg <= irq_en_next;
            rdata_reg <= rdata_next;
            report_reg <= report_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign corr_report = report_reg;
    assign crc_gen_enable = gen_en_reg;
    assign crc_check_enable = chk_en_reg;
    assign irq = |(irq_status_reg & irq_en_reg);
endmodule : aer_regs
`default_nettype wire

/* File: test/aer_regs_chk.sv */
// Port checker of the correctable mask and control bank
`include "aer_map.svh"
`default_nettype none
module aer_regs_chk (
    // Clock and resets
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic sticky_rst_n,
    // Register port
    input wire aer_pkg::aer_addr_t reg_addr,
    input wire aer_pkg::aer_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire aer_pkg::aer_word_t reg_rdata,
    // Events
    input wire logic ev_rcv_err,
    input wire logic ev_bad_pkt,
    input wire logic ev_bad_link_pkt,
    input wire logic ev_replay_roll,
    input wire logic ev_replay_to,
    input wire logic ev_advisory,
    // Outputs
    input wire logic corr_report,
    input wire logic crc_gen_enable,
    input wire logic crc_check_enable,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    import aer_pkg::*;
    aer_word_t msk_reg;
    aer_word_t msk_next;
    logic unm;
    // Shadow mask, sticky like the real one
    always_comb begin
        msk_next = msk_reg;
        if (reg_wr && reg_addr == `AER_OFF_CORR_MASK) msk_next = reg_wdata;
    end
    always_ff @(posedge sys_clk or negedge sticky_rst_n) begin
        if (!sticky_rst_n) msk_reg <= `AER_CORR_MASK_RST;
        else msk_reg <= msk_next;
    end
    assign unm = |({ev_advisory, ev_replay_to, ev_replay_roll, ev_bad_link_pkt, ev_bad_pkt,
        ev_rcv_err} & ~{msk_reg[13], msk_reg[12], msk_reg[8:6], msk_reg[0]});
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence ctrl_wr;
        reg_wr && reg_addr == `AER_OFF_ERR_CTRL;
    endsequence
    sequence rd_at(aer_addr_t a);
        reg_rd && reg_addr == a;
    endsequence
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    mask_read_a: assert property (rd_at(`AER_OFF_CORR_MASK) |=>
        reg_rdata == ($past(msk_reg) & (`AER_CORR_IMPL))) else $error("mask read wrong");
    ctrl_read_a: assert property (rd_at(`AER_OFF_ERR_CTRL) |=> reg_rdata[31:9] == 23'h0 &&
        reg_rdata[8] == $past(crc_check_enable) && reg_rdata[6] == $past(crc_gen_enable))
        else $error("control read disagrees with enables");
    rpt_event_a: assert property (unm |=> corr_report) else $error("unmasked event lost");
    rpt_cause_a: assert property (corr_report |-> $past(unm))
        else $error("report without an unmasked event");
    gen_wr_a: assert property (ctrl_wr |=> crc_gen_enable == $past(reg_wdata[6]))
        else $error("generation enable did not follow write");
    chk_wr_a: assert property (ctrl_wr |=> crc_check_enable == $past(reg_wdata[8]))
        else $error("check enable did not follow write");
    irq_off_a: assert property (reg_wr && reg_addr == `AER_OFF_IRQ_ENABLE &&
        reg_wdata[1:0] == 2'h0 |=> !irq) else $error("interrupt high while disabled");
endmodule : aer_regs_chk
bind aer_regs aer_regs_chk chk (.sys_clk, .resetn, .sticky_rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .ev_rcv_err, .ev_bad_pkt, .ev_bad_link_pkt, .ev_replay_roll,
    .ev_replay_to, .ev_advisory, .corr_report, .crc_gen_enable, .crc_check_enable, .irq);
`default_nettype wire

/* File: test/aer_rc_model.sv */
// Root complex stand-in that counts correctable error reports
`default_nettype none
module aer_rc_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Report from the port
    input wire logic corr_report,
    // Reports received
    output var logic [7:0] rpt_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_next;
    // Every report cycle is one message
    always_comb cnt_next = rpt_cnt + {7'h0, corr_report};
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) rpt_cnt <= 8'h0;
        else rpt_cnt <= cnt_next;
    end
endmodule : aer_rc_model
`default_nettype wire

/* File: test/tb_aer_correctable_mask_and_control.sv */
// Testbench of the correctable mask and control bank
`include "aer_map.svh"
`default_nettype none
module tb_aer_correctable_mask_and_control;
    timeunit 1ns;
    timeprecision 1ps;
    import aer_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic sticky_rst_n = 1'b0;
    aer_addr_t reg_addr = 12'h0;
    aer_word_t reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    aer_word_t reg_rdata;
    logic [5:0] ev = 6'h0;
    logic uerr_valid = 1'b0;
    aer_ptr_t uerr_bit = 5'h0;
    aer_word_t uerr_hdr [4] = '{default: 32'h0};
    logic corr_report, crc_gen_enable, crc_check_enable, irq;
    logic [7:0] rpt_cnt;
    logic [7:0] c0;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int pos [6] = '{0, 6, 7, 8, 12, 13};
    always #12.5 sys_clk = ~sys_clk;
    aer_regs uut (.sys_clk, .resetn, .sticky_rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .ev_rcv_err(ev[0]), .ev_bad_pkt(ev[1]), .ev_bad_link_pkt(ev[2]),
        .ev_replay_roll(ev[3]), .ev_replay_to(ev[4]), .ev_advisory(ev[5]), .uerr_valid,
        .uerr_bit, .uerr_hdr, .corr_report, .crc_gen_enable, .crc_check_enable, .irq);
    aer_rc_model rc (.sys_clk, .resetn, .corr_report, .rpt_cnt);
    task chk(input aer_word_t got, input aer_word_t exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit
    task wr(input aer_addr_t a, input aer_word_t v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        // Let the written value settle before any flag is looked at
        #1;
    endtask : wr
    // Data stand only in the cycle after the strobe
    task rd(input aer_addr_t a, input aer_word_t exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    task pulse(input logic [5:0] e);
        @(posedge sys_clk);
        ev <= e;
        @(posedge sys_clk);
        ev <= 6'h0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : pulse
    task uerr(input aer_ptr_t b, input aer_word_t base);
        @(posedge sys_clk);
        uerr_valid <= 1'b1;
        uerr_bit <= b;
        for (int k = 0; k < 4; k++) uerr_hdr[k] <= base + 32'(k);
        @(posedge sys_clk);
        uerr_valid <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask : uerr
    task print_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    // Tests need about two hundred cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        sticky_rst_n <= 1'b1;
        rd(`AER_OFF_CORR_MASK, 32'h00002000);
        rd(`AER_OFF_ERR_CTRL, 32'h000000a0);
        for (int k = 0; k < 4; k++) rd(`AER_OFF_HDR_LOG1 + 12'(4 * k), 32'h0);
        rd(12'h1fc, 32'h0);
        $display("test reset done");
        wr(`AER_OFF_CORR_MASK, 32'hffffffff);
        rd(`AER_OFF_CORR_MASK, 32'h000031c1);
        wr(`AER_OFF_CORR_MASK, 32'h0);
        for (int i = 0; i < 6; i++) begin
            c0 = rpt_cnt;
            pulse(6'h1 << i);
            chk(32'(rpt_cnt), 32'(c0) + 32'h1);
            rd(`AER_OFF_CORR_STATUS, 32'h1 << pos[i]);
            wr(`AER_OFF_CORR_STATUS, 32'h1 << pos[i]);
            rd(`AER_OFF_CORR_STATUS, 32'h0);
        end
        // Event and write-one clear in one cycle: the event wins
        fork
            wr(`AER_OFF_CORR_STATUS, 32'h00000040);
            pulse(6'h02);
        join
        rd(`AER_OFF_CORR_STATUS, 32'h00000040);
        wr(`AER_OFF_CORR_MASK, 32'h000031c1);
        c0 = rpt_cnt;
        for (int i = 0; i < 6; i++) pulse(6'h1 << i);
        chk(32'(rpt_cnt), 32'(c0));
        rd(`AER_OFF_CORR_STATUS, 32'h000031c1);
        wr(`AER_OFF_CORR_STATUS, 32'hffffffff);
        $display("test events done");
        wr(`AER_OFF_ERR_CTRL, 32'hffffffff);
        rd(`AER_OFF_ERR_CTRL, 32'h000001e0);
        chk_bit(crc_gen_enable, 1'b1);
        chk_bit(crc_check_enable, 1'b1);
        wr(`AER_OFF_LOCK, 32'h1);
        rd(`AER_OFF_LOCK, 32'h1);
        wr(`AER_OFF_ERR_CTRL, 32'h0);
        rd(`AER_OFF_ERR_CTRL, 32'h000000a0);
        chk_bit(crc_gen_enable, 1'b0);
        wr(`AER_OFF_LOCK, 32'h0);
        wr(`AER_OFF_ERR_CTRL, 32'h00000140);
        rd(`AER_OFF_ERR_CTRL, 32'h00000140);
        $display("test control done");
        wr(`AER_OFF_IRQ_CLEAR, 32'h3);
        wr(`AER_OFF_IRQ_ENABLE, 32'h3);
        rd(`AER_OFF_IRQ_ENABLE, 32'h3);
        chk_bit(irq, 1'b0);
        uerr(5'h12, 32'h10000000);
        for (int k = 0; k < 4; k++) rd(`AER_OFF_HDR_LOG1 + 12'(4 * k), 32'h10000000 + k);
        rd(`AER_OFF_ERR_CTRL, 32'h00000152);
        chk_bit(irq, 1'b1);
        rd(`AER_OFF_IRQ_STATUS, 32'h2);
        uerr(5'h04, 32'h20000000);
        wr(`AER_OFF_HDR_LOG1, 32'h0);
        rd(`AER_OFF_HDR_LOG1, 32'h10000000);
        rd(`AER_OFF_ERR_CTRL, 32'h00000152);
        wr(`AER_OFF_IRQ_ENABLE, 32'h0);
        chk_bit(irq, 1'b0);
        wr(`AER_OFF_IRQ_CLEAR, 32'h2);
        uerr(5'h04, 32'h20000000);
        rd(`AER_OFF_HDR_LOG4, 32'h20000003);
        rd(`AER_OFF_ERR_CTRL, 32'h00000144);
        $display("test log done");
        // Ordinary reset only: sticky fields stay, capability bits return
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(`AER_OFF_CORR_MASK, 32'h000031c1);
        rd(`AER_OFF_ERR_CTRL, 32'h000001e4);
        chk_bit(crc_check_enable, 1'b1);
        rd(`AER_OFF_HDR_LOG4, 32'h20000003);
        $display("test sticky done");
        print_verdict();
    end
endmodule : tb_aer_correctable_mask_and_control
`default_nettype wire
